// File: delta_sampler_consts.svh
// Constants for the delta bit sampler with slope overload detection.
// Assumes a single 50 MHz system clock and an asynchronous active-high reset.
`ifndef DELTA_SAMPLER_CONSTS_SVH
`define DELTA_SAMPLER_CONSTS_SVH

// ==========================================================================
// Rate select codes.
`define RATE_DIV1 2'h0
`define RATE_DIV2 2'h1
`define RATE_DIV4 2'h2

// ==========================================================================
// Reset values and FIFO sizing.
`define HIST_RESET 2'h0
`define FIFO_WIDTH 4
`define FIFO_DEPTH 16

// ==========================================================================
// Timing: fastest documented input clock and the system clock, in kHz.
`define CLK_KHZ      50000
`define MAX_BCLK_KHZ 500

`endif

// File: delta_sampler_pkg.sv
// Types for the delta bit sampler.
// Assumes the constants header is included where the types are used.
`include "delta_sampler_consts.svh"
package delta_sampler_pkg;
  // ========================================================================
  // One sampled bit in both of its presentations plus the overload flag.
  typedef struct packed {
    logic logic_bit;
    logic bipolar_pos;
    logic bipolar_neg;
    logic overload;
  } sample_s;
endpackage : delta_sampler_pkg

// File: delta_sampler.sv
// Sample FIFO and the delta bit sampler top.
// Assumes data and bit clock arrive asynchronously on pins.
`include "delta_sampler_consts.svh"

// ==========================================================================
// Generic FIFO with valid and ready on both sides.
module sample_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Next slot of a ring pointer. The depth is a power of two, so the
  // pointer wraps by itself when it steps past the last slot.
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] ptr);
    return ptr + AW'(1);
  endfunction : ptr_inc

  // Full and empty come from the occupancy count. It carries one spare bit,
  // so a full buffer and an empty one never look alike. Ready is low only
  // when every slot holds an unread word.
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr_reg];

  // Storage write.
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Write pointer steps on every accepted push.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= ptr_inc(wr_ptr_reg);
    end
  end

  // Read pointer steps on every accepted pop.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= ptr_inc(rd_ptr_reg);
    end
  end

  // Occupancy rises on a lone push and falls on a lone pop. It holds when a
  // push and a pop meet in one cycle.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_reg <= count_reg - (AW+1)'(1);
    end
  end
endmodule : sample_fifo

// ==========================================================================
// Delta bit sampler: divides the bit clock, samples data, flags overload.
module delta_sampler (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       bit_clk_i,
  input  wire logic       data_i,
  input  wire logic [1:0] rate_sel_i,
  output logic            logic_data_o,
  output logic            bipolar_pos_o,
  output logic            bipolar_neg_o,
  output logic            overload_o,
  output logic            sample_valid_o,
  input  wire logic       sample_ready_i,
  output logic            sample_stall_o
);
  // Synchroniser stages, divider, run history and the buffer handshake
  // all run on the system clock.

  logic [2:0] clk_sync_reg;
  logic [1:0] data_sync_reg;
  logic [1:0] div_cnt_reg;
  logic [1:0] rate_sync1_reg;
  logic [1:0] rate_sync2_reg;
  logic       bclk_rise;
  logic       sample_now;
  logic [1:0] hist_reg;
  logic [1:0] hist_fill_reg;
  logic       run_equal;
  delta_sampler_pkg::sample_s out_next;
  logic       fifo_in_ready;
  logic       fifo_out_valid;

  // Two-stage synchronisers for the pins and the rate select. The third
  // clock stage only delays the second one for the edge detector, so no
  // logic ever reads a first stage that may still be settling. Data and
  // clock pass the same number of stages, which keeps their alignment
  // as it was at the pins.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sync_reg   <= 3'h0;
      data_sync_reg  <= 2'h0;
      rate_sync1_reg <= `RATE_DIV1;
      rate_sync2_reg <= `RATE_DIV1;
    end else begin
      clk_sync_reg   <= {clk_sync_reg[1:0], bit_clk_i};
      data_sync_reg  <= {data_sync_reg[0], data_i};
      rate_sync1_reg <= rate_sel_i;
      rate_sync2_reg <= rate_sync1_reg;
    end
  end

  // Rising edge of the synchronised bit clock. Each level of the bit clock
  // must last at least one system clock to be seen, which leaves a wide
  // margin above the fastest bit clock the sampler has to follow.
  assign bclk_rise = clk_sync_reg[1] && !clk_sync_reg[2];

  // Divider: sample on every first, second or fourth rising edge. The count
  // restarts at each sample, so the phase of the divided clock is fixed by
  // the first bit clock edge after reset.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_reg <= 2'h0;
    end else if (bclk_rise) begin
      div_cnt_reg <= sample_now ? 2'h0 : div_cnt_reg + 2'h1;
    end
  end

  // Divide ratio decode; an unused select code behaves as divide by four.
  // The select is a slow switch level, so a change takes effect within a
  // few bit clock edges.
  always_comb begin
    unique case (rate_sync2_reg)
      `RATE_DIV1: sample_now = bclk_rise;
      `RATE_DIV2: sample_now = bclk_rise && (div_cnt_reg[0] == 1'b1);
      default:    sample_now = bclk_rise && (div_cnt_reg == 2'h3);
    endcase
  end

  // Run history of the two previous samples, updated once per sample. The
  // fill marks shift in a one per sample, so the flag can only be raised
  // once two real samples stand behind the new one; the reset contents of
  // the history are never taken for sampled bits.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hist_reg      <= `HIST_RESET;
      hist_fill_reg <= 2'h0;
    end else if (sample_now) begin
      hist_reg      <= {hist_reg[0], data_sync_reg[1]};
      hist_fill_reg <= {hist_fill_reg[0], 1'b1};
    end
  end

  // Three equal bits: the new sample matches both held ones. A run longer
  // than three keeps the flag up, since each new window is again all equal.
  assign run_equal = (data_sync_reg[1] == hist_reg[0]) && (hist_reg[0] == hist_reg[1]);

  // Next presentation of the sampled bit in both forms. The bipolar pair
  // is never equal, so exactly one level is driven at any time.
  always_comb begin
    out_next.logic_bit   = data_sync_reg[1];
    out_next.bipolar_pos = data_sync_reg[1];
    out_next.bipolar_neg = !data_sync_reg[1];
    out_next.overload    = run_equal && hist_fill_reg[1];
  end

  // Held outputs, changed only at a sample instant. Between samples they
  // keep the last bit, and the flag keeps its level, so downstream stages
  // can read them at any time.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      logic_data_o  <= 1'b0;
      bipolar_pos_o <= 1'b0;
      bipolar_neg_o <= 1'b1;
      overload_o    <= 1'b0;
    end else if (sample_now) begin
      logic_data_o  <= out_next.logic_bit;
      bipolar_pos_o <= out_next.bipolar_pos;
      bipolar_neg_o <= out_next.bipolar_neg;
      overload_o    <= out_next.overload;
    end
  end

  // Sample stream buffer for downstream logic. Every sample is offered
  // once, in the cycle in which the held outputs take it; its contents
  // stay internal and only the flow is visible at the ports.
  sample_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_data_i   (out_next),
    .in_valid_i  (sample_now),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (sample_ready_i)
  );

  // A sample offered while the buffer is full is flagged as lost. The held
  // outputs still take that sample; only the buffered copy is dropped, and
  // the stall pulse lasts exactly one cycle.
  assign sample_valid_o = fifo_out_valid;
  assign sample_stall_o = sample_now && !fifo_in_ready;
endmodule : delta_sampler

// File: delta_sampler_checker.sv
// Checker for the delta bit sampler, bound to its top module.
// Assumes one clock domain and a reset held high for at least one edge.
module delta_sampler_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic bit_clk_i,
  input wire logic logic_data_o,
  input wire logic bipolar_pos_o,
  input wire logic bipolar_neg_o,
  input wire logic overload_o,
  input wire logic sample_valid_o,
  input wire logic sample_ready_i,
  input wire logic sample_stall_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================================
  // Relations between sampling, levels, overload flag and the FIFO.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_neg; bipolar_neg_o != bipolar_pos_o; endproperty
  a_neg: assert property (p_neg) else $error("bipolar pair equal");
  property p_map; bipolar_pos_o == logic_data_o; endproperty
  a_map: assert property (p_map) else $error("bipolar level inverted");
  property p_hold;
    $changed(logic_data_o) |-> $past(bit_clk_i, 3) && !$past(bit_clk_i, 4);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved off a sample");
  property p_run; $rose(overload_o) |-> $stable(logic_data_o); endproperty
  a_run: assert property (p_run) else $error("flag rose on new bit");
  property p_brk; $changed(logic_data_o) |-> !overload_o; endproperty
  a_brk: assert property (p_brk) else $error("flag kept after break");
  property p_rst; $fell(rst_i) |-> !overload_o && !logic_data_o && !sample_valid_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_stall; sample_stall_o |=> !sample_stall_o ##0 sample_valid_o; endproperty
  a_stall: assert property (p_stall) else $error("stall not a pulse");
  property p_keep; sample_valid_o && !sample_ready_i |=> sample_valid_o; endproperty
  a_keep: assert property (p_keep) else $error("sample lost unpopped");
  c_rise: cover property ($rose(overload_o));
  c_fall: cover property ($fell(overload_o));
  c_full: cover property (sample_stall_o);
endmodule : delta_sampler_checker

bind delta_sampler delta_sampler_checker i_delta_sampler_checker (.*);

// File: delta_source.sv
// Far-side model: a delta bit source with its own bit clock.
// Assumes the bench clock; the bit clock runs only while run_i is high.
module delta_source (
  input  wire logic clock_i,
  input  wire logic run_i,
  input  wire logic bit_i,
  output logic      bit_clk_o,
  output logic      data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // ==================================================================
  // Data moves on the falling bit clock edge; idle data toggles.
  initial begin
    cnt = 4'h0;
    data_o = 1'b0;
  end
  always @(posedge clock_i) begin
    cnt <= run_i ? cnt + 4'h1 : 4'h0;
    if (!run_i) data_o <= ~data_o;
    else if (cnt == 4'hf) data_o <= bit_i;
  end
  assign bit_clk_o = cnt[3];
endmodule : delta_source

// File: delta_sampler_test.sv
// Self-checking bench for the delta bit sampler.
// Assumes the source model and the bound checker are compiled alongside.
module delta_sampler_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i, rst_i, bit_i, run_i, sample_ready_i;
  logic [1:0] rate_sel_i;
  logic       bit_clk_i, data_i, logic_data_o, bipolar_pos_o, bipolar_neg_o;
  logic       overload_o, sample_valid_o, sample_stall_o;
  int         errors, total_checks, stalls, pops, seed = 32'h0cb33414;
  logic       sent [0:19];
  delta_sampler i_delta_sampler (.*);
  delta_source i_delta_source (.clock_i, .run_i, .bit_i, .bit_clk_o(bit_clk_i), .data_o(data_i));
  // ==================================================================
  // Clock, and counters of stall pulses and FIFO pops.
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    stalls += int'(sample_stall_o);
    pops += int'(sample_valid_o & sample_ready_i);
  end
  // Expected held outputs for sent bit k, flag on three equal bits.
  function automatic logic [7:0] exp_out(input int k);
    return {4'h0, sent[k], sent[k], ~sent[k], sent[k] == sent[k-1] && sent[k-1] == sent[k-2]};
  endfunction : exp_out
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Reset, stream n bits at rate r with FIFO stalled, then drain and count.
  task automatic run_test(input logic [1:0] r, input int n, input int exp);
    rst_i <= 1'b1;
    rate_sel_i <= r;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    run_i <= 1'b1;
    stalls = 0;
    for (int j = 0; j < n; j++) begin
      if (r == 2'h0 && j >= 4) chk({4'h0, logic_data_o, bipolar_pos_o, bipolar_neg_o, overload_o}, exp_out(j - 2));
      sent[j] = j < 8 ? 1'(8'h38 >> j) : 1'($random(seed));
      bit_i <= sent[j];
      repeat (16) @(posedge clock_i);
    end
    run_i <= 1'b0;
    sample_ready_i <= 1'b1;
    pops = 0;
    repeat (40) @(posedge clock_i);
    sample_ready_i <= 1'b0;
    chk(8'(pops), 8'(exp));
    chk(8'(stalls), n > 16 ? 8'(n - 16) : 8'h0);
    $display("test rate %0d bits %0d done", r, n);
  endtask : run_test
  // ==================================================================
  // Every rate code, then an overfilled FIFO at full rate.
  initial begin
    rst_i = 1'b1;
    run_i = 1'b0;
    bit_i = 1'b0;
    sample_ready_i = 1'b0;
    rate_sel_i = 2'h0;
    for (int r = 0; r < 4; r++) run_test(2'(r), 8, r == 0 ? 8 : r == 1 ? 4 : 2);
    run_test(2'h0, 20, 16);
    final_report;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    errors++;
    final_report;
  end
endmodule : delta_sampler_test
